// ==== ddtb_map.svh ====
`ifndef DDTB_MAP_SVH
`define DDTB_MAP_SVH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define DDTB_CTRL_OFS     12'h000
`define DDTB_STAT_OFS     12'h004
`define DDTB_CYL_OFS      12'h008
`define DDTB_DIFF_OFS     12'h00c
`define DDTB_HEAD_OFS     12'h010
`define DDTB_CYLNOW_OFS   12'h014
// ---------------------------------------------------------------
// control bus bit positions under the control tag
// ---------------------------------------------------------------
`define DDTB_BIT_WRITE    0
`define DDTB_BIT_READ     1
`define DDTB_BIT_FWD      2
`define DDTB_BIT_ERASE    4
`define DDTB_BIT_REV      5
`define DDTB_BIT_HOME     6
// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define DDTB_CTRL_SEQPWR  0
`define DDTB_CTRL_RESET   32'h0000_0000
// ---------------------------------------------------------------
// timing: first-seek settle time in microseconds
// ---------------------------------------------------------------
`define DDTB_FIRST_SEEK_US 100
`define DDTB_CLK_MHZ       50
`define DDTB_FIRST_SEEK_CYC (`DDTB_FIRST_SEEK_US * `DDTB_CLK_MHZ)
`endif

// ==== ddtb_pkg.sv ====
package ddtb_pkg;
  typedef enum logic [1:0]
  {
    PWR_OFF,
    PWR_SEQ,
    PWR_READY
  } ddtb_pwr_t;
  typedef enum logic [2:0]
  {
    TAG_NONE,
    TAG_RDCYL,
    TAG_DIFF,
    TAG_CYL,
    TAG_HEAD,
    TAG_CTRL
  } ddtb_tag_t;
endpackage

// ==== ddtb_deck.sv ====
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "ddtb_map.svh"
// Notes on behaviour
// - bus has meaning only under exactly one asserted tag line.
// - control tag with bit 0 high enables the write drivers.
// - control tag with bit 1 high enables the read data output.
// - control tag with bit 2 high starts a forward carriage move.
// - control tag bit 4 is the erase gate.
// - control tag with bit 5 high starts a reverse carriage move.
// - control tag bit 6 returns carriage to cylinder zero; bits 3,7 unused.
// - first-seek completes before any read, write or seek is accepted.
// - first seek runs without selection and with little signalling.
// - difference tag loads bus as cylinder distance to travel.
// - head tag latches bus value as head selection.
module ddtb_deck #(
  parameter int unsigned FIRST_SEEK_CYC = `DDTB_FIRST_SEEK_CYC
)(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  busIn,
  output logic      [7:0]  busOut,
  output logic             busOe,
  input  wire logic        tagRdCyl,
  input  wire logic        tagDiff,
  input  wire logic        tagCyl,
  input  wire logic        tagHead,
  input  wire logic        tagCtrl,
  output logic             writeGate,
  output logic             readGate,
  output logic             eraseGate,
  output logic             seekFwd,
  output logic             seekRev,
  output logic             homeCylinderSeek,
  output logic             deckReady
);

  // ---------------------------------------------------------------
  // tag decode
  // ---------------------------------------------------------------
  logic [4:0] tagVec;
  logic       tagOne;
  ddtb_pkg::ddtb_tag_t tag;
  assign tagVec = {tagCtrl, tagHead, tagCyl, tagDiff, tagRdCyl};
  // two tags at once leave the bus undefined, so nothing is taken
  assign tagOne = (tagVec != 5'h00)
               && ((tagVec & (tagVec - 5'h01)) == 5'h00);

  always_comb
  begin
    tag = ddtb_pkg::TAG_NONE;
    if (tagOne)
    begin
      case (tagVec)
        5'h01:   tag = ddtb_pkg::TAG_RDCYL;
        5'h02:   tag = ddtb_pkg::TAG_DIFF;
        5'h04:   tag = ddtb_pkg::TAG_CYL;
        5'h08:   tag = ddtb_pkg::TAG_HEAD;
        5'h10:   tag = ddtb_pkg::TAG_CTRL;
        default: tag = ddtb_pkg::TAG_NONE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers and state
  // ---------------------------------------------------------------
  logic        seqPwr_q,   seqPwr_d;
  ddtb_pkg::ddtb_pwr_t pwr_q, pwr_d;
  logic [31:0] fsCnt_q,    fsCnt_d;
  logic [7:0]  cylNow_q,   cylNow_d;
  logic [7:0]  cylReq_q,   cylReq_d;
  logic [7:0]  diff_q,     diff_d;
  logic [7:0]  head_q,     head_d;
  logic [6:0]  gates_q,    gates_d;
  logic [7:0]  busOut_q,   busOut_d;
  logic        busOe_q,    busOe_d;
  logic [31:0] prdata_q,   prdata_d;
  logic        pready_q,   pready_d;
  logic        pslverr_q,  pslverr_d;
  logic        ready_q,    ready_d;
  logic        ready;
  logic        apbAcc;

  // ready is its own flop so that deckReady leaves a register directly
  assign ready  = ready_q;
  assign apbAcc = psel && !penable;

  // ---------------------------------------------------------------
  // first seek sequencing
  // ---------------------------------------------------------------
  always_comb
  begin
    pwr_d   = pwr_q;
    fsCnt_d = fsCnt_q;
    case (pwr_q)
      ddtb_pkg::PWR_OFF:
      begin
        fsCnt_d = 32'h0000_0000;
        // runs without any tag or unit selection
        if (seqPwr_q)
          pwr_d = ddtb_pkg::PWR_SEQ;
      end
      ddtb_pkg::PWR_SEQ:
      begin
        if (!seqPwr_q)
          pwr_d = ddtb_pkg::PWR_OFF;
        else if (fsCnt_q == FIRST_SEEK_CYC - 1)
          pwr_d = ddtb_pkg::PWR_READY;
        else
          fsCnt_d = fsCnt_q + 32'h0000_0001;
      end
      ddtb_pkg::PWR_READY:
      begin
        if (!seqPwr_q)
          pwr_d = ddtb_pkg::PWR_OFF;
      end
      default: pwr_d = ddtb_pkg::PWR_OFF;
    endcase
    // follows the state register edge for edge
    ready_d = (pwr_d == ddtb_pkg::PWR_READY);
  end

  // ---------------------------------------------------------------
  // tagged bus interpretation
  // ---------------------------------------------------------------
  always_comb
  begin
    cylReq_d = cylReq_q;
    diff_d   = diff_q;
    head_d   = head_q;
    cylNow_d = cylNow_q;
    gates_d  = gates_q;
    busOut_d = cylNow_q;
    busOe_d  = (tag == ddtb_pkg::TAG_RDCYL);
    // only the read-cylinder tag is answered until first seek is done; power loss drops gates
    if (!ready)
      gates_d = 7'h00;
    else
    begin
      case (tag)
        ddtb_pkg::TAG_CYL:  cylReq_d = busIn;
        ddtb_pkg::TAG_DIFF: diff_d   = busIn;
        ddtb_pkg::TAG_HEAD: head_d   = busIn;
        ddtb_pkg::TAG_CTRL:
        begin
          gates_d = busIn[6:0];
        end
        default: gates_d = gates_q;
      endcase
      // forward and reverse moves step the present cylinder by the difference; home clears it
      if (tag == ddtb_pkg::TAG_CTRL)
      begin
        if (busIn[`DDTB_BIT_HOME])
          cylNow_d = 8'h00;
        else if (busIn[`DDTB_BIT_FWD])
          cylNow_d = cylNow_q + diff_q;
        else if (busIn[`DDTB_BIT_REV])
          cylNow_d = cylNow_q - diff_q;
      end
    end
    if (pwr_q == ddtb_pkg::PWR_SEQ && fsCnt_q == FIRST_SEEK_CYC - 1)
      cylNow_d = 8'h00;
  end

  // ---------------------------------------------------------------
  // apb slave, one wait-free access phase
  // ---------------------------------------------------------------
  always_comb
  begin
    seqPwr_d  = seqPwr_q;
    prdata_d  = 32'h0000_0000;
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    if (apbAcc)
    begin
      pready_d = 1'b1;
      case (paddr)
        `DDTB_CTRL_OFS:   prdata_d = {31'h0000_0000, seqPwr_q};
        `DDTB_STAT_OFS:   prdata_d = {24'h00_0000, gates_q, ready};
        `DDTB_CYL_OFS:    prdata_d = {24'h00_0000, cylReq_q};
        `DDTB_DIFF_OFS:   prdata_d = {24'h00_0000, diff_q};
        `DDTB_HEAD_OFS:   prdata_d = {24'h00_0000, head_q};
        `DDTB_CYLNOW_OFS: prdata_d = {24'h00_0000, cylNow_q};
        default:          pslverr_d = 1'b1;
      endcase
    end
    // a write lands only at the edge that completes the access phase
    if (psel && penable && pready_q && pwrite && paddr == `DDTB_CTRL_OFS)
      seqPwr_d = pwdata[`DDTB_CTRL_SEQPWR];
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      seqPwr_q  <= 1'b0;
      pwr_q     <= ddtb_pkg::PWR_OFF;
      fsCnt_q   <= 32'h0000_0000;
      cylNow_q  <= 8'h00;
      cylReq_q  <= 8'h00;
      diff_q    <= 8'h00;
      head_q    <= 8'h00;
      gates_q   <= 7'h00;
      busOut_q  <= 8'h00;
      busOe_q   <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      ready_q   <= 1'b0;
    end
    else
    begin
      seqPwr_q  <= seqPwr_d;
      pwr_q     <= pwr_d;
      fsCnt_q   <= fsCnt_d;
      cylNow_q  <= cylNow_d;
      cylReq_q  <= cylReq_d;
      diff_q    <= diff_d;
      head_q    <= head_d;
      gates_q   <= gates_d;
      busOut_q  <= busOut_d;
      busOe_q   <= busOe_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      ready_q   <= ready_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata           = prdata_q;
  assign pready           = pready_q;
  assign pslverr          = pslverr_q;
  assign busOut           = busOut_q;
  assign busOe            = busOe_q;
  assign writeGate        = gates_q[`DDTB_BIT_WRITE];
  assign readGate         = gates_q[`DDTB_BIT_READ];
  assign seekFwd          = gates_q[`DDTB_BIT_FWD];
  assign eraseGate        = gates_q[`DDTB_BIT_ERASE];
  assign seekRev          = gates_q[`DDTB_BIT_REV];
  assign homeCylinderSeek = gates_q[`DDTB_BIT_HOME];
  assign deckReady        = ready;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_write_gate: assert property (
    (ready && tag == ddtb_pkg::TAG_CTRL) |=> writeGate == $past(busIn[0]))
    else $error("write gate does not follow bit 0");
  chk_read_gate: assert property (
    (ready && tag == ddtb_pkg::TAG_CTRL) |=> readGate == $past(busIn[1]))
    else $error("read gate does not follow bit 1");
  chk_erase_gate: assert property (
    (ready && tag == ddtb_pkg::TAG_CTRL) |=> eraseGate == $past(busIn[4]))
    else $error("erase gate does not follow bit 4");
  chk_seek_fwd: assert property (
    (ready && tag == ddtb_pkg::TAG_CTRL && busIn == 8'h04)
      |=> seekFwd && cylNow_q == $past(cylNow_q) + $past(diff_q))
    else $error("forward seek not started");
  chk_seek_rev: assert property (
    (ready && tag == ddtb_pkg::TAG_CTRL && busIn == 8'h20)
      |=> seekRev && cylNow_q == $past(cylNow_q) - $past(diff_q))
    else $error("reverse seek not started");
  chk_home_seek: assert property (
    (ready && tag == ddtb_pkg::TAG_CTRL && busIn[6])
      |=> homeCylinderSeek && cylNow_q == 8'h00)
    else $error("return to zero not taken");
  chk_not_ready: assert property (
    !ready |=> !writeGate && !readGate && !seekFwd && !seekRev)
    else $error("command accepted before first seek");
  chk_head_latch: assert property (
    (ready && tag == ddtb_pkg::TAG_HEAD) |=> head_q == $past(busIn))
    else $error("head select not latched");
  chk_diff_latch: assert property (
    (ready && tag == ddtb_pkg::TAG_DIFF) |=> diff_q == $past(busIn))
    else $error("difference not latched");
  chk_two_tags: assert property (
    (tagCtrl && tagHead) |=> $stable(gates_q) && $stable(head_q))
    else $error("bus taken under two tags");

  cov_first_seek: cover property (
    pwr_q == ddtb_pkg::PWR_SEQ ##1 pwr_q == ddtb_pkg::PWR_READY);
  cov_write: cover property (ready && tag == ddtb_pkg::TAG_CTRL && busIn[0]);
  cov_home: cover property (ready && tag == ddtb_pkg::TAG_CTRL && busIn[6]);
  cov_rdcyl: cover property (busOe);
  // overlapping tags must be seen at least once to exercise the refusal
  cov_two_tags: cover property (ready && tagCtrl && tagHead);

endmodule

// ==== ddtb_ctrl_model.sv ====
`timescale 1ns/1ps
// -------------------------------------------------
// controller side of the tag bus
// -------------------------------------------------
module ddtb_ctrl_model (
  input  wire logic                clk,
  input  wire ddtb_pkg::ddtb_tag_t reqTag,
  input  wire logic [7:0]          reqData,
  input  wire logic                reqDual,
  input  wire logic [7:0]          busOut,
  input  wire logic                busOe,
  output logic      [7:0]          busIn,
  output logic                     tagRdCyl,
  output logic                     tagDiff,
  output logic                     tagCyl,
  output logic                     tagHead,
  output logic                     tagCtrl
);
  ddtb_pkg::ddtb_tag_t tagQ = ddtb_pkg::TAG_NONE;
  logic [7:0]          drvQ = 8'h00;
  logic                dualQ = 1'b0;
  logic                own;
  // one tag per command, data held with it
  always @(posedge clk)
  begin
    tagQ <= reqTag;
    drvQ <= reqData;
    dualQ <= reqDual;
  end
  assign tagRdCyl = (tagQ == ddtb_pkg::TAG_RDCYL);
  assign tagDiff  = (tagQ == ddtb_pkg::TAG_DIFF);
  assign tagCyl   = (tagQ == ddtb_pkg::TAG_CYL);
  // dualQ raises the head tag beside another one: a deliberate fault case
  assign tagHead  = (tagQ == ddtb_pkg::TAG_HEAD) | dualQ;
  assign tagCtrl  = (tagQ == ddtb_pkg::TAG_CTRL);
  assign own      = tagDiff | tagCyl | tagHead | tagCtrl;
  // released bus shows the inverse so stale data never looks valid
  assign busIn = busOe ? busOut : (own ? drvQ : ~drvQ);
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
`include "ddtb_map.svh"
module tb;
  localparam int FSC = 8;
  logic        clk     = 1'b0;
  logic        resetn  = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready, pslverr, busOe, deckReady;
  logic [7:0]  busIn, busOut;
  logic        tRd, tDf, tCy, tHd, tCt;
  logic        wG, rG, eG, sF, sR, hS;
  ddtb_pkg::ddtb_tag_t reqTag = ddtb_pkg::TAG_NONE;
  logic [7:0]  reqData = 8'h00;
  logic        reqDual = 1'b0;
  logic        dualNext = 1'b0;
  logic [31:0] lfsr = 32'h0001_6673;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  d;
  int          n_errors = 0;
  int          checks_done = 0;
  int          n;
  wire  [5:0]  gOut = {hS, sR, eG, sF, rG, wG};

  ddtb_deck #(.FIRST_SEEK_CYC(FSC)) i_dut (.clk(clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .busIn(busIn), .busOut(busOut), .busOe(busOe), .tagRdCyl(tRd),
    .tagDiff(tDf), .tagCyl(tCy), .tagHead(tHd), .tagCtrl(tCt),
    .writeGate(wG), .readGate(rG), .eraseGate(eG), .seekFwd(sF),
    .seekRev(sR), .homeCylinderSeek(hS), .deckReady(deckReady));
  ddtb_ctrl_model i_ctl (.clk(clk), .reqTag(reqTag), .reqData(reqData),
    .reqDual(reqDual),
    .busOut(busOut), .busOe(busOe), .busIn(busIn), .tagRdCyl(tRd),
    .tagDiff(tDf), .tagCyl(tCy), .tagHead(tHd), .tagCtrl(tCt));

  initial
  begin
    forever #10 clk = ~clk;
  end

  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [5:0] expG(input logic [7:0] v);
    return {v[6], v[5], v[4], v[2], v[1], v[0]};
  endfunction

  task chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", what, e, g);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && k < 20)
    begin
      @(posedge clk);
      k++;
    end
    // answer taken at the same edge that samples pready high
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("apb wait", 0, k >= 20);
  endtask
  task send(input ddtb_pkg::ddtb_tag_t t, input logic [7:0] v);
    @(posedge clk);
    reqTag <= t;
    reqData <= v;
    reqDual <= dualNext;
    @(posedge clk);
    reqTag <= ddtb_pkg::TAG_NONE;
    reqDual <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task final_report;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    #200000;
    n_errors++;
    final_report();
  end

  initial
  begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1;
    chk("rst", 0, {gOut, deckReady, busOe});
    send(ddtb_pkg::TAG_CTRL, 8'h77);
    chk("unready gates", 0, gOut);
    apb(1'b0, 12'hffc, 0);
    chk("pslverr", 1, err);
    apb(1'b1, `DDTB_CTRL_OFS, 1);
    n = 0;
    while (deckReady !== 1'b1 && n < FSC + 20)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("ready", 1, deckReady);
    chk("ready early", 1, n >= FSC);
    apb(1'b0, `DDTB_STAT_OFS, 0);
    chk("stat", 1, rd[0]);
    // seeks, then read back the cylinder on the shared bus or over APB
    send(ddtb_pkg::TAG_DIFF, 8'h05);
    send(ddtb_pkg::TAG_CTRL, 8'h04);
    chk("fwd", expG(8'h04), gOut);
    send(ddtb_pkg::TAG_RDCYL, 8'h00);
    chk("oe", 1, busOe);
    chk("cyl fwd", 5, busOut);
    send(ddtb_pkg::TAG_DIFF, 8'h02);
    send(ddtb_pkg::TAG_CTRL, 8'h20);
    chk("rev", expG(8'h20), gOut);
    apb(1'b0, `DDTB_CYLNOW_OFS, 0);
    chk("cyl rev", 3, rd[7:0]);
    send(ddtb_pkg::TAG_CTRL, 8'h40);
    chk("home", expG(8'h40), gOut);
    send(ddtb_pkg::TAG_RDCYL, 8'h00);
    chk("cyl home", 0, busOut);
    // random gate bits, no carriage moves, plus latched values
    repeat (24)
    begin
      lfsr = step(lfsr);
      d = lfsr[7:0] & 8'h9b;
      send(ddtb_pkg::TAG_CTRL, d);
      chk("gates", expG(d), gOut);
      send(ddtb_pkg::TAG_HEAD, lfsr[15:8]);
      chk("gates hold", expG(d), gOut);
      apb(1'b0, `DDTB_HEAD_OFS, 0);
      chk("head", lfsr[15:8], rd[7:0]);
      send(ddtb_pkg::TAG_CYL, lfsr[23:16]);
      apb(1'b0, `DDTB_CYL_OFS, 0);
      chk("cyl req", lfsr[23:16], rd[7:0]);
      send(ddtb_pkg::TAG_DIFF, lfsr[31:24]);
      apb(1'b0, `DDTB_DIFF_OFS, 0);
      chk("diff", lfsr[31:24], rd[7:0]);
    end
    // two tags at once leave the bus undefined: nothing may be taken
    dualNext = 1'b1;
    send(ddtb_pkg::TAG_CTRL, 8'h47);
    dualNext = 1'b0;
    chk("two tags gates", expG(d), gOut);
    apb(1'b0, `DDTB_HEAD_OFS, 0);
    chk("two tags head", lfsr[15:8], rd[7:0]);
    apb(1'b1, `DDTB_CTRL_OFS, 0);
    repeat (2) @(posedge clk);
    #1;
    chk("power off", 0, {gOut, deckReady});
    final_report();
  end
endmodule
